// ===== rtl/ieemu_consts.svh
// Constants for the incremental encoder emulator
`ifndef IEEMU_CONSTS_SVH
`define IEEMU_CONSTS_SVH
`define IEEMU_CLK_HZ          20000000
`define IEEMU_FMAX_HZ         1000000
`define IEEMU_HALF_CYC        ((`IEEMU_CLK_HZ / `IEEMU_FMAX_HZ) / 2)
`define IEEMU_INDEX_NS        5000
`define IEEMU_CLK_NS          50
`define IEEMU_INDEX_CYC       (`IEEMU_INDEX_NS / `IEEMU_CLK_NS)
`define IEEMU_UPDATE_NS       42700
`define IEEMU_UPDATE_CYC      (`IEEMU_UPDATE_NS / `IEEMU_CLK_NS)
`define IEEMU_RES_RST         2'h3
`define IEEMU_MODE_RST        1'b0
`endif

// ===== rtl/ieemu_pkg.sv
// Types for the incremental encoder emulator
package ieemu_pkg;
  typedef enum logic [0:0] {
    IEEMU_MODE_AB   = 1'b0,
    IEEMU_MODE_STEP = 1'b1
  } ieemu_mode_t;
  typedef enum logic [1:0] {
    IEEMU_IDLE  = 2'b00,
    IEEMU_HIGH  = 2'b01,
    IEEMU_LOW   = 2'b11
  } ieemu_state_t;
endpackage

// ===== rtl/ieemu_top.sv
// Incremental encoder emulator: angle to A/B or step/direction pulses
`timescale 1ns/1ps
`include "ieemu_consts.svh"

module ieemu_top import ieemu_pkg::*; #(
  parameter int ANGLE_W   = 15,
  parameter int UPDATE_CYC = `IEEMU_UPDATE_CYC
) (
  input  wire logic               sys_clk,
  input  wire logic               reset,
  input  wire logic [ANGLE_W-1:0] angle_in,
  input  wire logic [1:0]         step_resolution_sel,
  input  wire logic               encoding_mode_sel,
  output logic                    phase_a_out,
  output logic                    phase_b_out,
  output logic                    index_out,
  output logic                    angle_sample
);
  localparam logic [3:0]  HALF     = 4'(`IEEMU_HALF_CYC);
  localparam logic [7:0]  IDX_CYC  = 8'(`IEEMU_INDEX_CYC);
  localparam logic [11:0] UPD_CYC  = 12'(UPDATE_CYC - 1);

  // ****************************************************************
  // Configuration and angle quantising
  // ****************************************************************
  logic [1:0]   res_reg;
  ieemu_mode_t  mode_reg;
  logic [11:0]  upd_cnt_reg;
  logic [11:0]  pos_reg;
  logic [11:0]  target_reg;
  logic         started_reg;
  logic [12:0]  diff;
  ieemu_state_t state_reg;
  logic [3:0]   half_cnt_reg;
  logic         dir_reg;
  logic [1:0]   quad_reg;
  logic         step_reg;
  logic [7:0]   idx_cnt_reg;

  // Quantise to the chosen resolution, scaled to the 12-bit step grid
  function automatic logic [11:0] quantise(input logic [ANGLE_W-1:0] a, input logic [1:0] res);
    logic [11:0] s;
    s = a[ANGLE_W-1 -: 12];
    quantise = s & ~12'((12'h007) >> res);
  endfunction

  // Step size on the 12-bit grid
  function automatic logic [11:0] step_size(input logic [1:0] res);
    step_size = 12'(12'h008 >> res);
  endfunction

  // ****************************************************************
  // Step arithmetic
  // ****************************************************************
  // Next Gray code of the phase pair; counting up puts B ahead of A
  function automatic logic [1:0] next_quad(input logic [1:0] q, input logic down);
    if (down) begin
      next_quad = {~q[0], q[1]};
    end else begin
      next_quad = {q[0], ~q[1]};
    end
  endfunction

  // Grid position one step further in the chosen direction
  function automatic logic [11:0] next_pos(input logic [11:0] p, input logic down, input logic [1:0] res);
    if (down) begin
      next_pos = p - step_size(res);
    end else begin
      next_pos = p + step_size(res);
    end
  endfunction

  // Defaults hold while reset is high; pins are read from the first free edge
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      res_reg  <= `IEEMU_RES_RST;
    end else begin
      res_reg  <= step_resolution_sel;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mode_reg <= ieemu_mode_t'(`IEEMU_MODE_RST);
    end else begin
      mode_reg <= ieemu_mode_t'(encoding_mode_sel);
    end
  end

  // Angle taken once per update period, like the sensor's filter output
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      upd_cnt_reg <= 12'h000;
    end else if (upd_cnt_reg == UPD_CYC) begin
      upd_cnt_reg <= 12'h000;
    end else begin
      upd_cnt_reg <= upd_cnt_reg + 12'h001;
    end
  end
  assign angle_sample = (upd_cnt_reg == UPD_CYC);

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      target_reg  <= 12'h000;
    end else if (angle_sample) begin
      target_reg  <= quantise(angle_in, res_reg);
    end
  end

  // No steps before the first angle arrives, so the host sees none at random
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      started_reg <= 1'b0;
    end else if (angle_sample) begin
      started_reg <= 1'b1;
    end
  end

  // Signed shortest-way distance; steps queue as this difference
  // A target more than half a turn away is reached the short way round
  assign diff = 13'({1'b0, target_reg} - {1'b0, pos_reg});

  // ****************************************************************
  // Pulse engine
  // ****************************************************************
  // Half period fixed by the 1 MHz ceiling, not by resolution, so a
  // coarse grid cannot spin faster
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_reg    <= IEEMU_IDLE;
      half_cnt_reg <= 4'h0;
      pos_reg      <= 12'h000;
      dir_reg      <= 1'b0;
      quad_reg     <= 2'b00;
      step_reg     <= 1'b0;
    end else begin
      unique case (state_reg)
        IEEMU_IDLE: begin
          if (started_reg && (pos_reg != (target_reg & ~(step_size(res_reg) - 12'h001)))) begin
            // Startup walks from zero to the absolute angle
            dir_reg      <= diff[11] ? 1'b1 : 1'b0;
            state_reg    <= IEEMU_HIGH;
            half_cnt_reg <= HALF - 4'h1;
            step_reg     <= 1'b1;
            quad_reg     <= next_quad(quad_reg, diff[11]);
          end
        end
        IEEMU_HIGH: begin
          if (half_cnt_reg == 4'h0) begin
            state_reg    <= IEEMU_LOW;
            half_cnt_reg <= HALF - 4'h1;
            step_reg     <= 1'b0;
          end else begin
            half_cnt_reg <= half_cnt_reg - 4'h1;
          end
        end
        IEEMU_LOW: begin
          if (half_cnt_reg == 4'h0) begin
            state_reg <= IEEMU_IDLE;
            pos_reg   <= next_pos(pos_reg, dir_reg, res_reg);
          end else begin
            half_cnt_reg <= half_cnt_reg - 4'h1;
          end
        end
        default: state_reg <= IEEMU_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Phase outputs
  // ****************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      phase_a_out <= 1'b0;
      phase_b_out <= 1'b0;
    end else if (mode_reg == IEEMU_MODE_AB) begin
      phase_a_out <= quad_reg[1];
      phase_b_out <= quad_reg[0];
    end else begin
      phase_a_out <= step_reg;
      phase_b_out <= dir_reg;
    end
  end

  // ****************************************************************
  // Index pulse
  // ****************************************************************
  // Index marks the step that takes the position across zero, either way
  // It retriggers if the position recrosses zero within one pulse
  logic zero_cross;
  assign zero_cross = (state_reg == IEEMU_LOW) && (half_cnt_reg == 4'h0) &&
                      (dir_reg ? (pos_reg == 12'h000) : (next_pos(pos_reg, 1'b0, res_reg) == 12'h000));

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      idx_cnt_reg <= 8'h00;
      index_out   <= 1'b0;
    end else if (zero_cross) begin
      idx_cnt_reg <= IDX_CYC - 8'h01;
      index_out   <= 1'b1;
    end else if (idx_cnt_reg != 8'h00) begin
      idx_cnt_reg <= idx_cnt_reg - 8'h01;
    end else begin
      index_out   <= 1'b0;
    end
  end
endmodule

// ===== sim/ieemu_chk.sv
// Port checker for the incremental encoder emulator
`timescale 1ns/1ps
module ieemu_chk #(
  parameter int ANGLE_W    = 15,
  parameter int UPDATE_CYC = 854
) (
  input wire logic               sys_clk,
  input wire logic               reset,
  input wire logic [ANGLE_W-1:0] angle_in,
  input wire logic [1:0]         step_resolution_sel,
  input wire logic               encoding_mode_sel,
  input wire logic               phase_a_out,
  input wire logic               phase_b_out,
  input wire logic               index_out,
  input wire logic               angle_sample
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic [9:0] smp_cnt;
  logic [7:0] idx_cnt;
  logic       got;
  always_ff @(posedge sys_clk) smp_cnt <= (reset || angle_sample) ? 10'h0 : smp_cnt + 10'h1;
  always_ff @(posedge sys_clk) idx_cnt <= (reset || !index_out) ? 8'h0 : idx_cnt + 8'h1;
  always_ff @(posedge sys_clk) got <= !reset && (got || angle_sample);
  // ****************
  // Pulse shapes, update period and reset idle
  // ****************
  sequence high10; phase_a_out[*5] ##1 phase_a_out[*5]; endsequence
  sequence low10; (!phase_a_out)[*5] ##1 (!phase_a_out)[*5]; endsequence
  sequence quiet8; ($stable(phase_a_out) && $stable(phase_b_out))[*8]; endsequence
  AST_STEP_PULSE: assert property (encoding_mode_sel && $rose(phase_a_out) |-> high10 ##1 low10)
    else $error("step pulse not 10 high 10 low");
  AST_AB_SPACING: assert property (!encoding_mode_sel && ($changed(phase_a_out) || $changed(phase_b_out))
    |=> quiet8 ##1 quiet8 ##1 ($stable(phase_a_out) && $stable(phase_b_out))[*3])
    else $error("quadrature edges closer than one step");
  AST_GRAY: assert property (!encoding_mode_sel |-> !($changed(phase_a_out) && $changed(phase_b_out)))
    else $error("both phases moved together");
  AST_DIR_HOLD: assert property (encoding_mode_sel && phase_a_out && $past(phase_a_out) |-> $stable(phase_b_out))
    else $error("direction moved during step pulse");
  AST_IDX_WIDTH: assert property ($fell(index_out) |-> idx_cnt == 8'h64)
    else $error("index pulse width wrong");
  AST_IDX_MAX: assert property (idx_cnt <= 8'h64)
    else $error("index pulse too long");
  AST_SMP_PERIOD: assert property (got && angle_sample |-> smp_cnt == UPDATE_CYC - 1)
    else $error("angle update period wrong");
  AST_SMP_MAX: assert property (smp_cnt < UPDATE_CYC)
    else $error("angle update missing");
  AST_RST_QUIET: assert property ($past(reset) |-> !phase_a_out && !phase_b_out && !index_out)
    else $error("outputs not idle after reset");
endmodule
bind ieemu_top ieemu_chk #(.ANGLE_W(ANGLE_W), .UPDATE_CYC(UPDATE_CYC)) ieemu_chk_i (.sys_clk, .reset, .angle_in,
  .step_resolution_sel, .encoding_mode_sel, .phase_a_out, .phase_b_out, .index_out, .angle_sample);

// ===== sim/ieemu_host_model.sv
// Host up/down counter fed by the emulator outputs
`timescale 1ns/1ps
module ieemu_host_model (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        phase_a_out,
  input  wire logic        phase_b_out,
  input  wire logic        index_out,
  input  wire logic        encoding_mode_sel,
  output logic      [11:0] host_count,
  output logic      [11:0] idx_seen
);
  logic pa, pb, pi;
  wire logic [1:0] g  = {phase_a_out, phase_a_out ^ phase_b_out};
  wire logic [1:0] pg = {pa, pa ^ pb};
  always_ff @(posedge sys_clk) {pa, pb, pi} <= {phase_a_out, phase_b_out, index_out};
  always_ff @(posedge sys_clk) idx_seen <= reset ? 12'h0 : idx_seen + {11'h0, index_out && !pi};
  // Clockwise counts up: B leads A, or B low in step mode
  always_ff @(posedge sys_clk) begin
    if (reset) host_count <= 12'h0;
    else if (encoding_mode_sel) begin
      if (phase_a_out && !pa) host_count <= phase_b_out ? host_count - 12'h1 : host_count + 12'h1;
    end else if (g != pg) host_count <= (g == pg + 2'h1) ? host_count + 12'h1 : host_count - 12'h1;
  end
endmodule

// ===== sim/tb_ieemu_top.sv
// Self-checking testbench for the incremental encoder emulator
`timescale 1ns/1ps
module tb_ieemu_top;
  logic        sys_clk = 1'b0, reset = 1'b1, encoding_mode_sel = 1'b0;
  logic [14:0] angle_in = 15'h0;
  logic [1:0]  step_resolution_sel = 2'h3;
  logic        phase_a_out, phase_b_out, index_out, angle_sample;
  logic [11:0] host_count, idx_seen, msk;
  int          n_fail = 0, compares = 0, seed = 32'h0534, i, k;
  always #25 sys_clk = ~sys_clk;
  ieemu_top #(.UPDATE_CYC(40)) ieemu_top_i (.sys_clk, .reset, .angle_in, .step_resolution_sel,
    .encoding_mode_sel, .phase_a_out, .phase_b_out, .index_out, .angle_sample);
  ieemu_host_model ieemu_host_model_i (.sys_clk, .reset, .phase_a_out, .phase_b_out, .index_out,
    .encoding_mode_sel, .host_count, .idx_seen);
  task check(string what, logic [11:0] exp, logic [11:0] got);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      n_fail++;
    end
  endtask
  task end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task start(logic mode, logic [1:0] res);
    reset = 1'b1;
    {encoding_mode_sel, step_resolution_sel, angle_in} = {mode, res, 15'h0};
    repeat (5) @(negedge sys_clk);
    reset = 1'b0;
    msk = (12'h200 << res) - 12'h1;
  endtask
  // Count expected in steps of the chosen resolution, wrapped per revolution
  task move(logic [11:0] a12);
    angle_in = {a12, 3'h0};
    for (k = 0; k < 12000 && (host_count & msk) !== ((a12 >> (3 - step_resolution_sel)) & msk); k++) @(negedge sys_clk);
    if (k == 12000) begin
      n_fail++;
      end_of_test();
    end else begin
      repeat (100) @(negedge sys_clk);
      check("count", (a12 >> (3 - step_resolution_sel)) & msk, host_count & msk);
      check("resync", 12'h000, ((a12 >> (3 - step_resolution_sel)) - host_count) & msk);
    end
  endtask
  initial begin
    start(1'b0, 2'h3);
    move(12'h005);
    move(12'hFFD);
    check("index", 12'h001, idx_seen);
    $display("test corner done");
    for (i = 0; i < 4; i++) begin
      start(i[0], 2'($random(seed)));
      move(12'($random(seed) & 32'h1FF) << (3 - step_resolution_sel));
      move(12'($random(seed) & 32'h1FF) << (3 - step_resolution_sel));
      $display("test %0d done", i);
    end
    end_of_test();
  end
endmodule
